// ---- rtl/indirect_bridge.sv ----
// host side bridge: indirect local access window and boot rom decode
//
// Summary of operation
// - local registers never decoded directly; only via command and data window.
// - local-map read/write codes reach memory-mapped registers and attention register.
// - local-io read/write codes reach all other local I/O registers.
// - same two host registers also reach private memory control blocks.
// - boot flash is 64K words of 16 bits.
// - upper 64 KB microcode, lower 64 KB host boot code.
// - boot rom config maps flash into host memory space.
// - rom response bit in private memory base selects flash window answer.
// - decode or memory enable clear: no response in flash window.
// - response bit clear: flash window reads all ones, registers still served.
// - all enables set and base value right: flash data returned.
// - memory space off: ignore all memory accesses, no device select.
`timescale 1ns/1ns
module indirect_bridge
    import bridge_pkg::*;
(
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    // enables from configuration space
    input  wire logic                pci_mem_space_on_in,
    input  wire logic                rom_window_decode_on_in,
    // host access, already region decoded
    input  wire logic                host_req_in,
    input  wire host_space_type      host_space_in,
    input  wire logic                host_write_in,
    input  wire logic [15:0]         host_addr_in,
    input  wire logic [3:0]          host_be_in,
    input  wire logic [31:0]         host_wdata_in,
    output logic                     host_ready_out,
    output logic                     host_devsel_out,
    output logic                     host_done_out,
    output logic [31:0]              host_rdata_out,
    // controller local bus
    output logic                     local_req_out,
    output logic                     local_write_out,
    output local_space_type          local_space_out,
    output logic [19:0]              local_addr_out,
    output logic [15:0]              local_wdata_out,
    input  wire logic                local_ack_in,
    input  wire logic [15:0]         local_rdata_in,
    // boot flash
    output logic                     flash_rd_out,
    output logic [FLASH_AW-1:0]      flash_addr_out,
    input  wire logic                flash_ack_in,
    input  wire logic [FLASH_DW-1:0] flash_data_in
);
    // ---------------------------------------------------------------
    // executors
    // ---------------------------------------------------------------
    xfer_if lx ();
    xfer_if fx ();

    local_port_engine u_local (
        .clk_in          (clk_in),
        .rst_n_in        (rst_n_in),
        .x               (lx.exec),
        .local_req_out   (local_req_out),
        .local_write_out (local_write_out),
        .local_space_out (local_space_out),
        .local_addr_out  (local_addr_out),
        .local_wdata_out (local_wdata_out),
        .local_ack_in    (local_ack_in),
        .local_rdata_in  (local_rdata_in)
    );

    boot_flash_reader u_flash (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .x              (fx.exec),
        .flash_rd_out   (flash_rd_out),
        .flash_addr_out (flash_addr_out),
        .flash_ack_in   (flash_ack_in),
        .flash_data_in  (flash_data_in)
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {HOST_IDLE, HOST_ROM, HOST_LOCAL} host_state_type;

    host_state_type state_reg, state_next;
    logic [23:0]    cmd_reg, cmd_next;
    logic           armed_reg, armed_next;
    logic [31:0]    data_reg, data_next;
    logic [15:0]    pmb_reg, pmb_next;
    logic           devsel_reg, devsel_next;
    logic           done_reg, done_next;
    logic [31:0]    rdata_reg, rdata_next;

    logic           take;
    logic           is_mem;
    logic           mem_claim;
    logic           rom_claim;
    logic           rom_live;
    logic           at_cmd;
    logic           at_data;
    logic [3:0]     op_in;
    logic [3:0]     op_cur;
    logic [31:0]    cmd_view;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    assign host_ready_out = (state_reg == HOST_IDLE);
    assign take           = host_req_in && host_ready_out;
    assign is_mem         = (host_space_in != SPACE_IO);
    // memory accesses vanish while memory space is off
    assign mem_claim      = !is_mem || pci_mem_space_on_in;
    // flash window answers only with both enables on
    assign rom_claim      = pci_mem_space_on_in && rom_window_decode_on_in;
    // flash data needs the response bit and the required base
    assign rom_live       = pmb_reg[ROM_RESP_BIT]
                            && (pmb_reg[15:1] == PMB_ROM_BASE[15:1]);
    // only two window offsets exist; local space is never mapped here
    assign at_cmd         = (host_addr_in[6:0] == HOST_CMD_OFF);
    assign at_data        = (host_addr_in[6:0] == HOST_DATA_OFF);
    assign op_in          = host_wdata_in[CMD_OP_LSB +: CMD_OP_W];
    assign op_cur         = cmd_reg[CMD_OP_LSB +: CMD_OP_W];
    assign cmd_view       = {lx.busy, armed_reg, 6'h00, cmd_reg};

    // ---------------------------------------------------------------
    // host access sequencing
    // ---------------------------------------------------------------
    always_comb begin
        state_next  = state_reg;
        cmd_next    = cmd_reg;
        armed_next  = armed_reg;
        data_next   = data_reg;
        pmb_next    = pmb_reg;
        devsel_next = 1'b0;
        done_next   = 1'b0;
        rdata_next  = rdata_reg;
        lx.start    = 1'b0;
        lx.write    = 1'b0;
        lx.space    = LOCAL_MAP;
        lx.addr     = cmd_reg[CMD_ADDR_W-1:0];
        lx.wdata    = data_reg[15:0];
        fx.start    = 1'b0;
        fx.write    = 1'b0;
        fx.space    = LOCAL_MAP;
        fx.addr     = {5'h00, host_addr_in[FLASH_AW-1:1]};
        fx.wdata    = 16'h0000;
        // local read result lands in the data window
        if (lx.done && !local_write_out) begin
            data_next = {16'h0000, lx.rdata};
        end
        unique case (state_reg)
            HOST_IDLE: begin
                if (take && host_space_in == SPACE_ROM) begin
                    if (rom_claim) begin
                        if (!host_write_in && rom_live) begin
                            fx.start   = 1'b1;
                            state_next = HOST_ROM;
                        end else begin
                            devsel_next = 1'b1;
                            done_next   = 1'b1;
                            rdata_next  = ALL_ONES;
                        end
                    end
                end else if (take && mem_claim) begin
                    devsel_next = 1'b1;
                    done_next   = 1'b1;
                    rdata_next  = 32'h0000_0000;
                    if (at_cmd) begin
                        rdata_next = cmd_view;
                    end else if (at_data) begin
                        rdata_next = data_reg;
                    end
                    if (host_write_in && at_cmd && !lx.busy) begin
                        cmd_next   = 24'(merge_bytes({8'h00, cmd_reg}, host_wdata_in,
                                                     host_be_in));
                        armed_next = 1'b0;
                        if (op_in == OP_MAP_READ || op_in == OP_IO_READ) begin
                            // address and code in, read starts at once
                            lx.start   = 1'b1;
                            lx.addr    = host_wdata_in[CMD_ADDR_W-1:0];
                            lx.space   = (op_in == OP_IO_READ) ? LOCAL_IO : LOCAL_MAP;
                            state_next = HOST_LOCAL;
                        end else if (op_in == OP_MAP_WRITE || op_in == OP_IO_WRITE) begin
                            armed_next = 1'b1;
                        end
                    end else if (host_write_in && at_data && !lx.busy) begin
                        data_next = merge_bytes(data_reg, host_wdata_in, host_be_in);
                        if (armed_reg) begin
                            // armed write goes out with the new data
                            armed_next = 1'b0;
                            lx.start   = 1'b1;
                            lx.write   = 1'b1;
                            lx.wdata   = data_next[15:0];
                            lx.space   = (op_cur == OP_IO_WRITE) ? LOCAL_IO : LOCAL_MAP;
                            state_next = HOST_LOCAL;
                            if (op_cur == OP_IO_WRITE && lx.addr == LOC_PRIV_MEM_BASE) begin
                                pmb_next = data_next[15:0];
                            end
                        end
                    end
                end
            end
            HOST_ROM: begin
                if (fx.done) begin
                    devsel_next = 1'b1;
                    done_next   = 1'b1;
                    rdata_next  = {16'h0000, fx.rdata};
                    state_next  = HOST_IDLE;
                end
            end
            HOST_LOCAL: begin
                if (lx.done) begin
                    state_next = HOST_IDLE;
                end
            end
            default: begin
                state_next = HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg  <= HOST_IDLE;
            cmd_reg    <= CMD_RESET;
            armed_reg  <= 1'b0;
            data_reg   <= DATA_RESET;
            pmb_reg    <= PMB_RESET;
            devsel_reg <= 1'b0;
            done_reg   <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            state_reg  <= state_next;
            cmd_reg    <= cmd_next;
            armed_reg  <= armed_next;
            data_reg   <= data_next;
            pmb_reg    <= pmb_next;
            devsel_reg <= devsel_next;
            done_reg   <= done_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign host_devsel_out = devsel_reg;
    assign host_done_out   = done_reg;
    assign host_rdata_out  = rdata_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_local_only_indirect : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(local_req_out) |-> $past(take && host_write_in && (at_cmd || at_data)))
        else $error("local access without host command or data write");
    a_map_op_space : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        lx.start && (lx.write ? op_cur == OP_MAP_WRITE : op_in == OP_MAP_READ)
        |=> local_space_out == LOCAL_MAP)
        else $error("local-map code went to the wrong space");
    a_io_op_space : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        lx.start && (lx.write ? op_cur == OP_IO_WRITE : op_in == OP_IO_READ)
        |=> local_space_out == LOCAL_IO)
        else $error("local-io code went to the wrong space");
    a_read_fills_data : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        lx.done && !local_write_out |=> data_reg[15:0] == $past(local_rdata_in, 2))
        else $error("data window missed the local read");
    a_rom_off_silent : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && host_space_in == SPACE_ROM && !rom_window_decode_on_in
        |=> !host_devsel_out && state_reg == HOST_IDLE)
        else $error("flash window answered with decode off");
    a_rom_ones : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && host_space_in == SPACE_ROM && rom_claim && !pmb_reg[ROM_RESP_BIT] && !host_write_in
        |=> host_done_out && host_rdata_out == ALL_ONES)
        else $error("flash window did not read all ones");
    a_mem_off_silent : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && is_mem && !pci_mem_space_on_in |=> !host_devsel_out ##1 !host_devsel_out)
        else $error("memory access claimed with memory space off");
    a_rom_data : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_reg == HOST_ROM && fx.done
        |=> host_devsel_out && host_rdata_out[15:0] == $past(flash_data_in, 2))
        else $error("flash data not returned");
    a_data_kept_write : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        lx.done && local_write_out |=> $stable(data_reg))
        else $error("local write changed the data window");
    a_local_holds_host : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        local_req_out |-> !host_ready_out)
        else $error("host taken while local transfer runs");
    a_flash_holds_host : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        flash_rd_out |-> !host_ready_out)
        else $error("host taken while flash read runs");
endmodule : indirect_bridge

// ---- rtl/bridge_pkg.sv ----
// constants and types for the indirect local access and boot rom bridge
package bridge_pkg;
    // ---------------------------------------------------------------
    // host register window offsets
    // ---------------------------------------------------------------
    localparam logic [6:0]  HOST_DATA_OFF   = 7'h10;
    localparam logic [6:0]  HOST_CMD_OFF    = 7'h14;
    // ---------------------------------------------------------------
    // indirect command register layout
    // ---------------------------------------------------------------
    localparam int          CMD_ADDR_W      = 20;
    localparam int          CMD_OP_LSB      = 20;
    localparam int          CMD_OP_W        = 4;
    localparam int          CMD_ARMED_BIT   = 30;
    localparam int          CMD_BUSY_BIT    = 31;
    localparam logic [3:0]  OP_NONE         = 4'h0;
    localparam logic [3:0]  OP_MAP_READ     = 4'h1;
    localparam logic [3:0]  OP_MAP_WRITE    = 4'h2;
    localparam logic [3:0]  OP_IO_READ      = 4'h3;
    localparam logic [3:0]  OP_IO_WRITE     = 4'h4;
    localparam logic [23:0] CMD_RESET       = 24'h00_0000;
    localparam logic [31:0] DATA_RESET      = 32'h0000_0000;
    // ---------------------------------------------------------------
    // local register map
    // ---------------------------------------------------------------
    localparam logic [19:0] LOC_RING_READ_PTR   = 20'hcde02;
    localparam logic [19:0] LOC_RING_WIN_OFF    = 20'hcde04;
    localparam logic [19:0] LOC_CTRL_STATUS     = 20'hcde08;
    localparam logic [19:0] LOC_CTRL_IRQ_STATUS = 20'hcde0b;
    localparam logic [19:0] LOC_RX_BUF_REGION   = 20'hcde10;
    localparam logic [19:0] LOC_RX_EARLY_LEVEL  = 20'hcde12;
    localparam logic [19:0] LOC_PROC_ATTENTION  = 20'h0180d;
    localparam logic [19:0] LOC_PRIV_MEM_BASE   = 20'h01c80;
    localparam logic [19:0] LOC_BOARD_SWITCHES  = 20'h01c88;
    localparam logic [19:0] LOC_SPROM_CONTROL   = 20'h01c8a;
    localparam logic [19:0] LOC_SPROM_WORD      = 20'h01c8c;
    // ---------------------------------------------------------------
    // private memory base shadow and boot rom
    // ---------------------------------------------------------------
    localparam int          ROM_RESP_BIT    = 0;
    localparam logic [15:0] PMB_RESET       = 16'h0000;
    localparam logic [15:0] PMB_ROM_BASE    = 16'hf9c0;
    localparam int          FLASH_AW        = 16;
    localparam int          FLASH_DW        = 16;
    localparam logic        ROM_HOST_HALF   = 1'b0;
    localparam logic [31:0] ALL_ONES        = 32'hffff_ffff;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {SPACE_IO, SPACE_MMIO, SPACE_ROM} host_space_type;
    typedef enum logic {LOCAL_MAP, LOCAL_IO} local_space_type;
endpackage : bridge_pkg

// ---- rtl/xfer_if.sv ----
// one word transfer request between the bridge and its executors
`timescale 1ns/1ns
interface xfer_if;
    import bridge_pkg::*;
    logic                  start;
    logic                  write;
    local_space_type       space;
    logic [19:0]           addr;
    logic [15:0]           wdata;
    logic                  busy;
    logic                  done;
    logic [15:0]           rdata;
    modport ctrl (output start, write, space, addr, wdata, input busy, done, rdata);
    modport exec (input start, write, space, addr, wdata, output busy, done, rdata);
endinterface : xfer_if

// ---- rtl/local_port_engine.sv ----
// runs one read or write on the controller's local bus
`timescale 1ns/1ns
module local_port_engine
    import bridge_pkg::*;
(
    // clock and reset
    input  wire logic            clk_in,
    input  wire logic            rst_n_in,
    // request side
    xfer_if.exec                 x,
    // local bus
    output logic                 local_req_out,
    output logic                 local_write_out,
    output local_space_type      local_space_out,
    output logic [19:0]          local_addr_out,
    output logic [15:0]          local_wdata_out,
    input  wire logic            local_ack_in,
    input  wire logic [15:0]     local_rdata_in
);
    logic            req_reg, req_next;
    logic            write_reg, write_next;
    local_space_type space_reg, space_next;
    logic [19:0]     addr_reg, addr_next;
    logic [15:0]     wdata_reg, wdata_next;
    logic            done_reg, done_next;
    logic [15:0]     rdata_reg, rdata_next;

    always_comb begin
        req_next   = req_reg;
        write_next = write_reg;
        space_next = space_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        done_next  = 1'b0;
        if (req_reg && local_ack_in) begin
            req_next  = 1'b0;
            done_next = 1'b1;
            if (!write_reg) begin
                rdata_next = local_rdata_in;
            end
        end else if (!req_reg && x.start) begin
            req_next   = 1'b1;
            write_next = x.write;
            space_next = x.space;
            addr_next  = x.addr;
            wdata_next = x.wdata;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_reg   <= 1'b0;
            write_reg <= 1'b0;
            space_reg <= LOCAL_MAP;
            addr_reg  <= 20'h00000;
            wdata_reg <= 16'h0000;
            done_reg  <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            req_reg   <= req_next;
            write_reg <= write_next;
            space_reg <= space_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            done_reg  <= done_next;
            rdata_reg <= rdata_next;
        end
    end

    assign x.busy          = req_reg;
    assign x.done          = done_reg;
    assign x.rdata         = rdata_reg;
    assign local_req_out   = req_reg;
    assign local_write_out = write_reg;
    assign local_space_out = space_reg;
    assign local_addr_out  = addr_reg;
    assign local_wdata_out = wdata_reg;
endmodule : local_port_engine

// ---- rtl/boot_flash_reader.sv ----
// reads one 16-bit word from the host half of the boot flash
`timescale 1ns/1ns
module boot_flash_reader
    import bridge_pkg::*;
(
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    // request side
    xfer_if.exec                     x,
    // flash
    output logic                     flash_rd_out,
    output logic [FLASH_AW-1:0]      flash_addr_out,
    input  wire logic                flash_ack_in,
    input  wire logic [FLASH_DW-1:0] flash_data_in
);
    logic                rd_reg, rd_next;
    logic [FLASH_AW-1:0] addr_reg, addr_next;
    logic                done_reg, done_next;
    logic [FLASH_DW-1:0] data_reg, data_next;

    always_comb begin
        rd_next   = rd_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        done_next = 1'b0;
        if (rd_reg && flash_ack_in) begin
            rd_next   = 1'b0;
            done_next = 1'b1;
            data_next = flash_data_in;
        end else if (!rd_reg && x.start) begin
            rd_next   = 1'b1;
            // host sees only the boot code half of the part
            addr_next = {ROM_HOST_HALF, x.addr[FLASH_AW-2:0]};
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_reg   <= 1'b0;
            addr_reg <= '0;
            done_reg <= 1'b0;
            data_reg <= '0;
        end else begin
            rd_reg   <= rd_next;
            addr_reg <= addr_next;
            done_reg <= done_next;
            data_reg <= data_next;
        end
    end

    assign x.busy         = rd_reg;
    assign x.done         = done_reg;
    assign x.rdata        = data_reg;
    assign flash_rd_out   = rd_reg;
    assign flash_addr_out = addr_reg;

    a_host_half : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        flash_rd_out |-> flash_addr_out[FLASH_AW-1] == ROM_HOST_HALF)
        else $error("flash read left the boot code half");
endmodule : boot_flash_reader

// ---- verification/local_far_model.sv ----
// far side model: controller local space and boot flash
`timescale 1ns/1ns
module local_far_model
    import bridge_pkg::*;
(
    // clock
    input  wire logic            clk_in,
    // local bus
    input  wire logic            req_in,
    input  wire logic            write_in,
    input  wire local_space_type space_in,
    input  wire logic [19:0]     addr_in,
    input  wire logic [15:0]     wdata_in,
    output logic                 ack_out,
    output logic [15:0]          rdata_out,
    // flash
    input  wire logic            flash_rd_in,
    input  wire logic [15:0]     flash_addr_in,
    output logic                 flash_ack_out,
    output logic [15:0]          flash_data_out
);
    logic [15:0] mem [logic [20:0]];
    int          dly = 0;
    initial begin
        ack_out = 1'b0;
        rdata_out = 16'h0;
        flash_ack_out = 1'b0;
        flash_data_out = 16'h0;
    end
    // released lines toggle so stale data never looks valid
    always @(negedge clk_in) begin
        ack_out <= 1'b0;
        flash_ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        flash_data_out <= ~flash_data_out;
        if (req_in && !ack_out && dly-- == 0) begin
            dly = $urandom_range(0, 3);
            ack_out <= 1'b1;
            if (write_in) mem[{space_in, addr_in}] = wdata_in;
            else rdata_out <= mem.exists({space_in, addr_in}) ? mem[{space_in, addr_in}] : ~rdata_out;
        end
        if (flash_rd_in && !flash_ack_out) begin
            flash_ack_out <= 1'b1;
            flash_data_out <= ~flash_addr_in;
        end
    end
endmodule : local_far_model

// ---- verification/tb_top.sv ----
// self-checking bench for the indirect bridge
`timescale 1ns/1ns
module tb_top;
    import bridge_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, pci_mem_space_on_in = 1'b0, rom_window_decode_on_in = 1'b0;
    logic host_req_in = 1'b0, host_write_in = 1'b0, claimed;
    host_space_type host_space_in = SPACE_IO;
    logic [15:0] host_addr_in = 16'h0, local_wdata_out, local_rdata_in, flash_addr_out, flash_data_in, a;
    logic [3:0] host_be_in = 4'hf;
    logic [31:0] host_wdata_in = 32'h0, host_rdata_out, got, d;
    logic host_ready_out, host_devsel_out, host_done_out, local_req_out, local_write_out, local_ack_in;
    logic flash_rd_out, flash_ack_in;
    local_space_type local_space_out;
    logic [19:0] local_addr_out, la;
    int n_fail = 0, num_checks = 0, cyc = 0;
    indirect_bridge DUT (.*);
    local_far_model far (.clk_in(clk_in), .req_in(local_req_out), .write_in(local_write_out),
        .space_in(local_space_out), .addr_in(local_addr_out), .wdata_in(local_wdata_out),
        .ack_out(local_ack_in), .rdata_out(local_rdata_in), .flash_rd_in(flash_rd_out),
        .flash_addr_in(flash_addr_out), .flash_ack_out(flash_ack_in), .flash_data_out(flash_data_in));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic acc(input host_space_type sp, input logic wr, input logic [15:0] ad, input logic [31:0] wd);
        while (!host_ready_out) @(negedge clk_in);
        host_req_in = 1'b1;
        host_space_in = sp;
        host_write_in = wr;
        host_addr_in = ad;
        host_wdata_in = wd;
        @(negedge clk_in);
        host_req_in = 1'b0;
        claimed = 1'b0;
        for (int n = 0; n < 20 && !claimed; n++) begin
            claimed = host_devsel_out;
            got = host_rdata_out;
            if (!claimed) @(negedge clk_in);
        end
        if (claimed) chk(32'(host_done_out), 32'h1);
        @(negedge clk_in);
    endtask : acc
    function automatic logic [31:0] exp_flash(input logic [15:0] ad);
        return {16'h0, ~{1'b0, ad[15:1]}};
    endfunction : exp_flash
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        d = $urandom(55);
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        pci_mem_space_on_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            // only listed local addresses are programmed
            la = i[0] ? (i[1] ? LOC_SPROM_WORD : LOC_BOARD_SWITCHES) : (i[1] ? LOC_PROC_ATTENTION : LOC_RX_BUF_REGION);
            d = $urandom;
            acc(SPACE_IO, 1'b1, 16'h0014, {8'h0, i[0] ? OP_IO_WRITE : OP_MAP_WRITE, la});
            acc(i[2] ? SPACE_MMIO : SPACE_IO, 1'b1, 16'h0010, d);
            acc(SPACE_IO, 1'b0, 16'h0010, 32'h0);
            chk(got, d);
            acc(SPACE_IO, 1'b1, 16'h0014, {8'h0, i[0] ? OP_IO_READ : OP_MAP_READ, la});
            acc(SPACE_MMIO, 1'b0, 16'h0010, 32'h0);
            chk(got, {16'h0, d[15:0]});
        end
        $display("test indirect done");
        pci_mem_space_on_in = 1'b0;
        rom_window_decode_on_in = 1'b1;
        acc(SPACE_ROM, 1'b0, 16'h0004, 32'h0);
        chk(32'(claimed), 32'h0);
        acc(SPACE_MMIO, 1'b0, 16'h0010, 32'h0);
        chk(32'(claimed), 32'h0);
        pci_mem_space_on_in = 1'b1;
        rom_window_decode_on_in = 1'b0;
        acc(SPACE_ROM, 1'b0, 16'h0004, 32'h0);
        chk(32'(claimed), 32'h0);
        rom_window_decode_on_in = 1'b1;
        acc(SPACE_ROM, 1'b0, 16'h0004, 32'h0);
        chk(got, ALL_ONES);
        acc(SPACE_MMIO, 1'b0, 16'h0010, 32'h0);
        chk(32'(claimed), 32'h1);
        acc(SPACE_IO, 1'b1, 16'h0014, {8'h0, OP_IO_WRITE, LOC_PRIV_MEM_BASE});
        acc(SPACE_IO, 1'b1, 16'h0010, {16'h0, PMB_ROM_BASE | 16'h0001});
        for (int i = 0; i < 6; i++) begin
            a = 16'($urandom);
            acc(SPACE_ROM, 1'b0, a, 32'h0);
            chk(got, exp_flash(a));
        end
        acc(SPACE_ROM, 1'b1, 16'h0004, 32'h0);
        chk(got, ALL_ONES);
        $display("test flash window done");
        end_sim();
    end
endmodule : tb_top
